/* verilog/wdt_top.sv */
// Watchdog timeout unit with its register port and reset pin drive.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module wdt_top
#(
    parameter logic [17:0] TIMEOUT_SHORT = wdt_pkg::LIMIT_SHORT,
    parameter logic [17:0] TIMEOUT_LONG  = wdt_pkg::LIMIT_LONG
)
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port.
    input  wire wdt_pkg::wdt_bus_t bus,
    output logic [7:0]             rdata,
    // Reset vector low byte at the service address.
    input  wire logic [7:0]        reset_vector_low,
    // Configuration bits.
    input  wire logic              watchdog_disable,
    input  wire logic              long_timeout_select,
    // Operating modes and pin levels.
    input  wire wdt_pkg::wdt_mode_t mode,
    input  wire logic              internal_reset,
    input  wire logic              vector_fetch,
    // Reset pin, open drain.
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe,
    // Status outputs.
    output logic                   watchdog_reset,
    output logic                   watchdog_enable,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    wdt_pkg::wdt_top_st_t st;
    wdt_pkg::wdt_top_st_t next_st;

    logic [17:0] count;
    logic        tmo;
    logic        drive;
    logic        svc_wr;
    logic        sts_wr;
    logic        por_clr;
    logic        clr_pre;
    logic        run;
    logic        disable_now;
    logic [1:0]  st_set;
    logic [1:0]  st_clr;

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks.

    if (TIMEOUT_SHORT <= {13'h0000, wdt_pkg::PULSE_LAST} + 18'h00001
        || TIMEOUT_LONG < TIMEOUT_SHORT)
    begin : g_bad_limits
        $error("Timeout limits must exceed the pulse and be ordered.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic wr_hit(input wdt_pkg::wdt_bus_t b,
                                    input logic [15:0]       a);
        return b.wr && (b.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Chain and pulse.

    wdt_chain
    #(
        .LIM_SHORT (TIMEOUT_SHORT),
        .LIM_LONG  (TIMEOUT_LONG)
    )
    u_chain
    (
        .clk      (clk),
        .rst      (rst),
        .run      (run),
        .long_sel (long_timeout_select),
        .clr_pre  (clr_pre),
        .clr_svc  (svc_wr),
        .clr_all  (internal_reset),
        .count    (count),
        .tmo      (tmo)
    );

    wdt_pulse u_pulse
    (
        .clk   (clk),
        .rst   (rst),
        .start (tmo),
        .drive (drive)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control terms.

    always_comb
    begin
        svc_wr = wr_hit(bus, wdt_pkg::ADDR_SERVICE);
        sts_wr = wr_hit(bus, wdt_pkg::ADDR_STATUS);
        por_clr = !st.por_done &&
                  (st.por_cnt == wdt_pkg::POR_CYC - 13'h0001);
        clr_pre = mode.stop_exec || vector_fetch || por_clr;
        disable_now = watchdog_disable
                    || (mode.monitor_mode
                        && (mode.hv_reset_pin || mode.hv_irq_pin))
                    || (mode.break_state && mode.hv_reset_pin);
        run = st.enable && !mode.stop_mode;
        st_set = '0;
        st_set[wdt_pkg::ST_TIMEOUT] = tmo;
        st_set[wdt_pkg::ST_SERVICE] = svc_wr;
        st_clr = sts_wr ? bus.wdata[1:0] : 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        next_st = st;
        next_st.enable = !disable_now;
        next_st.pin_level = 1'b0;
        if (!st.por_done)
        begin
            if (por_clr)
            begin
                next_st.por_done = 1'b1;
            end
            else
            begin
                next_st.por_cnt = st.por_cnt + 13'h0001;
            end
        end
        next_st.status = (st.status & ~st_clr) | st_set;
        if (wr_hit(bus, wdt_pkg::ADDR_MASK))
        begin
            next_st.mask = bus.wdata[1:0];
        end
        next_st.irq = |(next_st.status & next_st.mask);
        next_st.rdata = 8'h00;
        if (bus.rd)
        begin
            unique case (bus.addr)
                wdt_pkg::ADDR_SERVICE:
                begin
                    next_st.rdata = reset_vector_low;
                end
                wdt_pkg::ADDR_STATUS:
                begin
                    next_st.rdata = {6'h00, st.status};
                end
                wdt_pkg::ADDR_MASK:
                begin
                    next_st.rdata = {6'h00, st.mask};
                end
                wdt_pkg::ADDR_COUNT:
                begin
                    next_st.rdata = {2'h0, count[17:wdt_pkg::PRE_W]};
                end
                wdt_pkg::ADDR_STATE:
                begin
                    next_st.rdata = {5'h00, drive, long_timeout_select,
                                     st.enable};
                end
                default:
                begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign rdata           = st.rdata;
    assign reset_pin_out   = st.pin_level;
    assign reset_pin_oe    = drive;
    assign watchdog_reset  = drive;
    assign watchdog_enable = st.enable;
    assign irq             = st.irq;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_timeout_point: assert property (
        @(posedge clk) disable iff (rst)
        (run && !clr_pre && !svc_wr && !internal_reset
         && count == (long_timeout_select ? TIMEOUT_LONG : TIMEOUT_SHORT)
                     - 18'h00001)
        |=> tmo)
        else $error("Timeout missed at the limit.");

    a_service_clear: assert property (
        @(posedge clk) disable iff (rst)
        svc_wr |=> (count[17:3] == 15'h0000))
        else $error("Service write did not clear the count.");

    a_read_vector: assert property (
        @(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == wdt_pkg::ADDR_SERVICE)
        |=> (rdata == $past(reset_vector_low)))
        else $error("Service read did not return the vector.");

    a_pulse_length: assert property (
        @(posedge clk) disable iff (rst)
        $rose(reset_pin_oe) |-> reset_pin_oe[*8] ##24 reset_pin_oe
                                ##1 !reset_pin_oe)
        else $error("Reset pin pulse is not 32 cycles.");

    a_timeout_flag: assert property (
        @(posedge clk) disable iff (rst)
        tmo |=> (st.status[0] && reset_pin_oe && !reset_pin_out))
        else $error("Timeout did not flag and drive the pin.");

    a_monitor_off: assert property (
        @(posedge clk) disable iff (rst)
        (mode.monitor_mode && (mode.hv_irq_pin || mode.hv_reset_pin))
        |=> !watchdog_enable)
        else $error("Watchdog ran in monitor mode.");

    a_break_off: assert property (
        @(posedge clk) disable iff (rst)
        (mode.break_state && mode.hv_reset_pin) |=> !watchdog_enable)
        else $error("Watchdog ran in break state.");

    a_stop_freeze: assert property (
        @(posedge clk) disable iff (rst)
        (mode.stop_mode && !clr_pre && !svc_wr && !internal_reset)
        |=> $stable(count))
        else $error("Count moved in stop mode.");

    a_prescale_clear: assert property (
        @(posedge clk) disable iff (rst)
        (clr_pre && !internal_reset) |=> (count[11:0] == 12'h000))
        else $error("Prescaler not cleared.");

    a_internal_reset: assert property (
        @(posedge clk) disable iff (rst)
        internal_reset |=> (count == 18'h00000))
        else $error("Internal reset did not clear the chain.");

    a_enable_output: assert property (
        @(posedge clk) disable iff (rst)
        (mode.monitor_mode && !mode.hv_irq_pin && !mode.hv_reset_pin
         && !watchdog_disable && !mode.break_state) |=> watchdog_enable)
        else $error("Enable output not asserted.");

    a_disable_high: assert property (
        @(posedge clk) disable iff (rst)
        watchdog_disable |=> !watchdog_enable)
        else $error("Disable input did not stop the watchdog.");

    a_disable_hold: assert property (
        @(posedge clk) disable iff (rst)
        (!watchdog_enable && !clr_pre && !svc_wr && !internal_reset)
        |=> $stable(count))
        else $error("Count moved while disabled.");

    a_count_step: assert property (
        @(posedge clk) disable iff (rst)
        (run && !clr_pre && !svc_wr && !internal_reset
         && count != (long_timeout_select ? TIMEOUT_LONG : TIMEOUT_SHORT)
                     - 18'h00001)
        |=> (count == $past(count) + 18'h00001))
        else $error("Count did not step while running.");

    a_pulse_middle: assert property (
        @(posedge clk) disable iff (rst)
        $rose(reset_pin_oe) |-> ##8 reset_pin_oe[*8] ##1 reset_pin_oe[*8]
                                ##1 reset_pin_oe[*7])
        else $error("Reset pin pulse broke off early.");

    a_status_sticky: assert property (
        @(posedge clk) disable iff (rst)
        (st.status[wdt_pkg::ST_TIMEOUT]
         && !(sts_wr && bus.wdata[wdt_pkg::ST_TIMEOUT]))
        |=> st.status[wdt_pkg::ST_TIMEOUT])
        else $error("Timeout flag lost without a clear.");

    a_status_clear: assert property (
        @(posedge clk) disable iff (rst)
        (sts_wr && bus.wdata[wdt_pkg::ST_TIMEOUT] && !tmo)
        |=> !st.status[wdt_pkg::ST_TIMEOUT])
        else $error("Timeout flag not cleared by a one.");

    a_service_flag: assert property (
        @(posedge clk) disable iff (rst)
        svc_wr |=> st.status[wdt_pkg::ST_SERVICE])
        else $error("Service write not flagged.");

    a_read_status: assert property (
        @(posedge clk) disable iff (rst)
        (bus.rd && bus.addr == wdt_pkg::ADDR_STATUS)
        |=> (rdata == {6'h00, $past(st.status)}))
        else $error("Status read returned the wrong value.");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (rst)
        !bus.rd |=> (rdata == 8'h00))
        else $error("Read data shown without a read.");

    a_idle_off: assert property (
        @(posedge clk) disable iff (rst)
        !watchdog_enable |=> !tmo)
        else $error("Timeout while the watchdog was off.");

    a_stop_quiet: assert property (
        @(posedge clk) disable iff (rst)
        mode.stop_mode |=> !tmo)
        else $error("Timeout while in stop mode.");

    a_stop_clear: assert property (
        @(posedge clk) disable iff (rst)
        (mode.stop_exec && !internal_reset)
        |=> (count[wdt_pkg::PRE_W-1:0] == '0))
        else $error("Stop did not clear the prescaler.");

    a_vector_clear: assert property (
        @(posedge clk) disable iff (rst)
        (vector_fetch && !internal_reset)
        |=> (count[wdt_pkg::PRE_W-1:0] == '0))
        else $error("Vector fetch did not clear the prescaler.");

    a_long_limit: assert property (
        @(posedge clk) disable iff (rst)
        (run && long_timeout_select && TIMEOUT_SHORT < TIMEOUT_LONG
         && count == TIMEOUT_SHORT - 18'h00001)
        |=> !tmo)
        else $error("Short limit fired with long timeout selected.");

endmodule

/* verilog/wdt_pkg.sv */
// Shared constants and types for the watchdog timeout unit.
// What this block does
// - Six-bit counter behind twelve-bit prescaler, oscillator clocked.
// - Overflow after limit cycles, chosen by rate.
// - Any service write clears counter, prescaler stages 4-12.
// - Service read returns reset vector low byte.
// - Timeout drives reset pin low 32 cycles, flags.
// - Monitor mode high voltage on either pin disables.
// - Break state high voltage on reset pin disables.
// - Stop clears prescaler; stop mode freezes the count.
// - Power-on logic clears prescaler after 4096 cycles.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable and rate inputs follow configuration bits.
// - Counting continues in wait mode.
// - Timeout resets and flags; irq raised for flags enabled in the mask.
// - High voltage removed in monitor asserts enable output.
package wdt_pkg;

    localparam int unsigned CNT_W  = 18;
    localparam int unsigned PRE_W  = 12;
    localparam int unsigned SVC_LO = 3;
    localparam int unsigned ST_W   = 2;

    localparam logic [15:0] ADDR_SERVICE = 16'hFFFF;
    localparam logic [15:0] ADDR_STATUS  = 16'hFF00;
    localparam logic [15:0] ADDR_MASK    = 16'hFF01;
    localparam logic [15:0] ADDR_COUNT   = 16'hFF02;
    localparam logic [15:0] ADDR_STATE   = 16'hFF03;

    localparam int unsigned ST_TIMEOUT = 0;
    localparam int unsigned ST_SERVICE = 1;

    localparam logic [17:0] LIMIT_SHORT = 18'h01FF0;
    localparam logic [17:0] LIMIT_LONG  = 18'h3FFF0;
    localparam logic [12:0] POR_CYC     = 13'h1000;
    localparam logic [4:0]  PULSE_LAST  = 5'h1F;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } wdt_bus_t;

    typedef struct packed {
        logic monitor_mode;
        logic break_state;
        logic hv_reset_pin;
        logic hv_irq_pin;
        logic stop_mode;
        logic stop_exec;
    } wdt_mode_t;

    typedef enum logic [1:0] {
        WDT_IDLE  = 2'b00,
        WDT_DRIVE = 2'b01
    } wdt_pulse_st_t;

    typedef struct packed {
        logic [17:0] count;
        logic        tmo;
    } wdt_chain_st_t;

    typedef struct packed {
        wdt_pulse_st_t fsm;
        logic [4:0]    cnt;
        logic          drive;
    } wdt_pulse_reg_t;

    typedef struct packed {
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [7:0]  rdata;
        logic [12:0] por_cnt;
        logic        por_done;
        logic        enable;
        logic        irq;
        logic        pin_level;
    } wdt_top_st_t;

endpackage

/* verilog/wdt_chain.sv */
// Prescaler and timeout counter chain of the watchdog.
`timescale 1ns/100ps
module wdt_chain
#(
    parameter logic [17:0] LIM_SHORT = wdt_pkg::LIMIT_SHORT,
    parameter logic [17:0] LIM_LONG  = wdt_pkg::LIMIT_LONG
)
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Control.
    input  wire logic        run,
    input  wire logic        long_sel,
    input  wire logic        clr_pre,
    input  wire logic        clr_svc,
    input  wire logic        clr_all,
    // State.
    output logic [17:0]      count,
    output logic             tmo
);

    wdt_pkg::wdt_chain_st_t st;
    wdt_pkg::wdt_chain_st_t next_st;
    logic [17:0]            limit;

    if (LIM_SHORT < 18'h00002 || LIM_LONG < LIM_SHORT)
    begin : g_bad
        $error("Timeout limits out of range.");
    end

    always_comb
    begin
        next_st = st;
        next_st.tmo = 1'b0;
        limit = long_sel ? LIM_LONG : LIM_SHORT;
        if (clr_all)
        begin
            next_st.count = '0;
        end
        else if (clr_pre || clr_svc)
        begin
            if (clr_pre)
            begin
                next_st.count[wdt_pkg::PRE_W-1:0] = '0;
            end
            if (clr_svc)
            begin
                next_st.count[17:wdt_pkg::SVC_LO] = '0;
            end
        end
        else if (run)
        begin
            if (st.count == limit - 18'h00001)
            begin
                next_st.count = '0;
                next_st.tmo = 1'b1;
            end
            else
            begin
                next_st.count = st.count + 18'h00001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign tmo   = st.tmo;

endmodule

/* verilog/wdt_pulse.sv */
// Stretcher that holds the reset pin low after a timeout.
`timescale 1ns/100ps
module wdt_pulse
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Trigger and pin drive.
    input  wire logic start,
    output logic      drive
);

    wdt_pkg::wdt_pulse_reg_t st;
    wdt_pkg::wdt_pulse_reg_t next_st;

    always_comb
    begin
        next_st = st;
        unique case (st.fsm)
            wdt_pkg::WDT_IDLE:
            begin
                if (start)
                begin
                    next_st.fsm = wdt_pkg::WDT_DRIVE;
                    next_st.cnt = '0;
                    next_st.drive = 1'b1;
                end
            end
            wdt_pkg::WDT_DRIVE:
            begin
                if (st.cnt == wdt_pkg::PULSE_LAST)
                begin
                    next_st.fsm = wdt_pkg::WDT_IDLE;
                    next_st.drive = 1'b0;
                end
                else
                begin
                    next_st.cnt = st.cnt + 5'h01;
                end
            end
            default:
            begin
                next_st = '0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign drive = st.drive;

endmodule

/* verif/testbench.sv */
// Self-checking testbench for the watchdog timeout unit.
`timescale 1ns/100ps
module testbench;

    localparam int L  = 64;
    localparam int LL = 128;

    logic               clk;
    logic               rst;
    wdt_pkg::wdt_bus_t  bus;
    logic [7:0]         rdata;
    logic [7:0]         reset_vector_low;
    logic               watchdog_disable;
    logic               long_timeout_select;
    wdt_pkg::wdt_mode_t mode;
    logic               internal_reset;
    logic               vector_fetch;
    logic               reset_pin_out;
    logic               reset_pin_oe;
    logic               watchdog_reset;
    logic               watchdog_enable;
    logic               irq;
    int                 num_errors;
    int                 compares;
    int                 cycles;
    logic [4:0]         tbl [6];

    wdt_top
    #(
        .TIMEOUT_SHORT (18'h00040),
        .TIMEOUT_LONG  (18'h00080)
    )
    wdt_top_i
    (
        .clk                 (clk),
        .rst                 (rst),
        .bus                 (bus),
        .rdata               (rdata),
        .reset_vector_low    (reset_vector_low),
        .watchdog_disable    (watchdog_disable),
        .long_timeout_select (long_timeout_select),
        .mode                (mode),
        .internal_reset      (internal_reset),
        .vector_fetch        (vector_fetch),
        .reset_pin_out       (reset_pin_out),
        .reset_pin_oe        (reset_pin_oe),
        .watchdog_reset      (watchdog_reset),
        .watchdog_enable     (watchdog_enable),
        .irq                 (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, cycle limit and reporting.

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Register port and event tasks.

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pulse_ireset();
        @(posedge clk);
        internal_reset <= 1'b1;
        @(posedge clk);
        internal_reset <= 1'b0;
    endtask

    // Waits for the reset pin drive, checks its delay and its length.
    task automatic tmo_check(input int lo, input int hi);
        int n;
        int w;
        n = 0;
        w = 0;
        while (reset_pin_oe !== 1'b1 && n < hi + 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n >= lo && n <= hi, 1);
        while (reset_pin_oe === 1'b1 && w < 40)
        begin
            chk({reset_pin_out, watchdog_reset}, 2'b01);
            @(posedge clk);
            #1;
            w++;
        end
        chk(w, 32);
    endtask

    // Checks that no reset pin drive appears for n cycles.
    task automatic no_tmo(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (reset_pin_oe !== 1'b0)
                bad = 1'b1;
        end
        chk(bad, 0);
    endtask

    task automatic set_dis(input logic v);
        @(posedge clk);
        watchdog_disable <= v;
        repeat (3) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.

    initial
    begin
        num_errors = 0;
        compares = 0;
        cycles = 0;
        rst = 1'b1;
        bus = '0;
        reset_vector_low = 8'hA5;
        watchdog_disable = 1'b1;
        long_timeout_select = 1'b0;
        mode = '0;
        internal_reset = 1'b0;
        vector_fetch = 1'b0;
        tbl = '{5'b10010, 5'b10100, 5'b10001, 5'b01100, 5'b01011, 5'b00111};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({rdata, reset_pin_oe, irq, watchdog_enable}, 11'h000);
        rd(16'hFF00, 8'h00);
        rd(16'hFF01, 8'h00);
        rd(16'hFFFF, 8'hA5);
        @(posedge clk);
        #1;
        chk(rdata, 8'h00);
        rd(16'hFF10, 8'h00);
        rd(16'hFF03, 8'h00);
        no_tmo(4100);
        @(posedge clk);
        watchdog_disable <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            mode <= {tbl[i][4:1], 2'b00};
            repeat (3) @(posedge clk);
            #1;
            chk(watchdog_enable, tbl[i][0]);
        end
        @(posedge clk);
        mode <= '0;
        wr(16'hFFFF, 8'h5A);
        rd(16'hFF00, 8'h02);
        wr(16'hFF00, 8'h03);
        tmo_check(L - 12, L + 2);
        set_dis(1'b1);
        rd(16'hFF00, 8'h01);
        chk(irq, 0);
        wr(16'hFF01, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, 1);
        wr(16'hFF00, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, 0);
        wr(16'hFF01, 8'h00);
        long_timeout_select <= 1'b1;
        set_dis(1'b0);
        rd(16'hFF03, 8'h03);
        wr(16'hFFFF, 8'h00);
        tmo_check(LL - 10, LL + 2);
        set_dis(1'b1);
        long_timeout_select <= 1'b0;
        set_dis(1'b0);
        pulse_ireset();
        tmo_check(L - 2, L + 4);
        set_dis(1'b1);
        set_dis(1'b0);
        wr(16'hFFFF, 8'h00);
        repeat (40) @(posedge clk);
        vector_fetch <= 1'b1;
        @(posedge clk);
        vector_fetch <= 1'b0;
        tmo_check(L - 2, L + 4);
        set_dis(1'b1);
        set_dis(1'b0);
        wr(16'hFFFF, 8'h00);
        repeat (30) @(posedge clk);
        mode <= '{stop_mode: 1'b1, stop_exec: 1'b1, default: 1'b0};
        @(posedge clk);
        mode <= '{stop_mode: 1'b1, default: 1'b0};
        no_tmo(200);
        @(posedge clk);
        mode <= '0;
        tmo_check(L - 3, L + 4);
        conclude();
    end

endmodule
